// file: rtl/adcct_ctrl.sv
// adcct_ctrl: sample, compare and transfer sequencer for a 10-bit
// successive-approximation converter, with range clamping and power control.
// assumes an analog front end that holds its sample while sample_sw is low and
// a comparator that reports whether the held input is at or above the dac trial level.
//
// Summary of operation
// - all phases counted in half_clock_unit, half a cpu clock period each
// - timing codes are the top four bits of the control word
// - each start samples first, then resolves ten bits by successive comparison
// - conversion time is sample plus comparison plus result transfer time
// - input changes after sampling ends do not affect the result
// - input below ground gives all zeros, above reference gives all ones
// - power-off bit switches the analog circuitry off
// - codes 00/00: sample 120, compare 240, extra 28
// - codes 00/01: sample 140, compare 280, extra 16
// - codes 00/10: sample 200, compare 280, extra 52
// - codes 00/11: sample 400, compare 280, extra 44
// - codes 11/00: sample 240, compare 480, extra 52
// - codes 11/01: sample 280, compare 560, extra 28
// - codes 11/10: sample 400, compare 560, extra 100
// - codes 11/11: sample 800, compare 560, extra 52
// - codes 10/00: sample 480, compare 960, extra 100
// - codes 10/01: sample 560, compare 1120, extra 52
// - codes 10/10: sample 800, compare 1120, extra 196
// - codes 10/11: sample 1600, compare 1120, extra 64
`timescale 1ns/1ps
module adcct_ctrl (
    // clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          rstn,
    // converter_control_register contents and start request
    input  wire logic [adcct_pkg::CTRL_W-1:0]  ctrl_word,
    input  wire logic                          conv_start,
    // analog front end, asynchronous to ref_clk
    input  wire logic                          cmp_above,
    input  wire logic                          in_below_gnd,
    input  wire logic                          in_above_ref,
    // analog front end controls
    output logic                               analog_en_q,
    output logic                               sample_sw_q,
    output logic      [adcct_pkg::RES_W-1:0]   dac_code_q,
    // status and result
    output logic                               busy_q,
    output logic      [1:0]                    phase_q,
    output logic      [adcct_pkg::RES_W-1:0]   result_q,
    output logic                               result_valid_q,
    output logic                               range_clamped_q
);

    typedef enum logic [1:0] {
        ADCCT_IDLE,
        ADCCT_SAMPLE,
        ADCCT_COMPARE,
        ADCCT_XFER
    } adcct_state_t;

    adcct_state_t                     state_q;
    adcct_state_t                     state_d;

    logic [1:0]                       ctc;
    logic [1:0]                       stc;
    logic                             pwr_off;
    logic [1:0]                       ctc_q;
    logic [1:0]                       stc_q;
    logic                             tbl_ready_q;
    logic [adcct_pkg::CNT_W-1:0]      smp_cyc;
    logic [adcct_pkg::CNT_W-1:0]      step_cyc;
    logic [adcct_pkg::CNT_W-1:0]      ext_cyc;
    logic [adcct_pkg::CNT_W-1:0]      cnt_q;
    logic                             cnt_done;
    logic [adcct_pkg::BIT_W-1:0]      bit_q;
    logic [adcct_pkg::RES_W-1:0]      sar_q;
    logic [adcct_pkg::RES_W-1:0]      sar_keep;
    logic                             below_q;
    logic                             above_q;
    logic                             smp_end;
    logic                             cmp_end;
    logic                             conv_end;

    // two-stage synchronisers for the analog status lines
    logic                             cmp_m_q;
    logic                             cmp_s_q;
    logic                             blw_m_q;
    logic                             blw_s_q;
    logic                             abv_m_q;
    logic                             abv_s_q;

    // mask with only the given result bit set
    function automatic logic [adcct_pkg::RES_W-1:0] bit_mask(
        input logic [adcct_pkg::BIT_W-1:0] pos
    );
        bit_mask = adcct_pkg::RES_W'(1) << pos;
    endfunction

    assign ctc     = ctrl_word[adcct_pkg::CTC_MSB:adcct_pkg::CTC_LSB];
    assign stc     = ctrl_word[adcct_pkg::STC_MSB:adcct_pkg::STC_LSB];
    assign pwr_off = ctrl_word[adcct_pkg::PWR_OFF_BIT];

    // timing codes frozen for the whole conversion; a mid-run change of the
    // control word would otherwise stretch or cut the remaining steps and
    // leave a result whose timing matches no row of the table
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctc_q <= 2'h0;
            stc_q <= 2'h0;
        end else if (state_d == ADCCT_IDLE) begin
            ctc_q <= ctc;
            stc_q <= stc;
        end
    end

    // the table lags the frozen codes by a cycle, so a start is held off
    // until it has caught up; a stale row would mistime the first phase
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tbl_ready_q <= 1'b0;
        end else begin
            tbl_ready_q <= ({ctc_q, stc_q} == {ctc, stc});
        end
    end

    // table answers a cycle after the frozen codes
    adcct_timing_rom u_timing (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .ctc        (ctc_q),
        .stc        (stc_q),
        .smp_cyc_q  (smp_cyc),
        .step_cyc_q (step_cyc),
        .ext_cyc_q  (ext_cyc)
    );

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cmp_m_q <= 1'b0;
            cmp_s_q <= 1'b0;
            blw_m_q <= 1'b0;
            blw_s_q <= 1'b0;
            abv_m_q <= 1'b0;
            abv_s_q <= 1'b0;
        end else begin
            cmp_m_q <= cmp_above;
            cmp_s_q <= cmp_m_q;
            blw_m_q <= in_below_gnd;
            blw_s_q <= blw_m_q;
            abv_m_q <= in_above_ref;
            abv_s_q <= abv_m_q;
        end
    end

    assign cnt_done = (cnt_q == '0);
    // comparator high means the held input is at or above the trial level
    assign sar_keep = cmp_s_q ? dac_code_q : sar_q;

    // phase boundaries shared by the sequencer and the datapath; the
    // transfer end is ignored once power is off, so an abort loads nothing
    assign smp_end  = (state_q == ADCCT_SAMPLE) && cnt_done;
    assign cmp_end  = (state_q == ADCCT_COMPARE) && cnt_done && (bit_q == '0);
    assign conv_end = (state_q == ADCCT_XFER) && cnt_done && !pwr_off;

    // sequence: sample, ten compare steps, then the result transfer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ADCCT_IDLE: begin
                if (conv_start && !pwr_off && tbl_ready_q) begin
                    state_d = ADCCT_SAMPLE;
                end
            end
            ADCCT_SAMPLE: begin
                if (pwr_off) begin
                    state_d = ADCCT_IDLE;
                end else if (cnt_done) begin
                    state_d = ADCCT_COMPARE;
                end
            end
            ADCCT_COMPARE: begin
                if (pwr_off) begin
                    state_d = ADCCT_IDLE;
                end else if (cmp_end) begin
                    state_d = ADCCT_XFER;
                end
            end
            ADCCT_XFER: begin
                if (pwr_off || cnt_done) begin
                    state_d = ADCCT_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ADCCT_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // phase counter is loaded with length minus one so each phase is exact
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else begin
            unique case (state_q)
                ADCCT_IDLE: begin
                    cnt_q <= smp_cyc - adcct_pkg::CNT_W'(1);
                end
                ADCCT_SAMPLE: begin
                    if (cnt_done) begin
                        cnt_q <= step_cyc - adcct_pkg::CNT_W'(1);
                    end else begin
                        cnt_q <= cnt_q - adcct_pkg::CNT_W'(1);
                    end
                end
                ADCCT_COMPARE: begin
                    if (cnt_done && bit_q == '0) begin
                        cnt_q <= ext_cyc - adcct_pkg::CNT_W'(1);
                    end else if (cnt_done) begin
                        cnt_q <= step_cyc - adcct_pkg::CNT_W'(1);
                    end else begin
                        cnt_q <= cnt_q - adcct_pkg::CNT_W'(1);
                    end
                end
                ADCCT_XFER: begin
                    cnt_q <= cnt_q - adcct_pkg::CNT_W'(1);
                end
            endcase
        end
    end

    // sample switch: closed only during the sample phase, so later input
    // movement cannot reach the held charge
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sample_sw_q <= 1'b0;
        end else begin
            sample_sw_q <= (state_d == ADCCT_SAMPLE);
        end
    end

    // range flags are frozen at the end of sampling with the held voltage
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            below_q <= 1'b0;
            above_q <= 1'b0;
        end else if (smp_end) begin
            below_q <= blw_s_q;
            above_q <= abv_s_q;
        end
    end

    // successive approximation register and trial level
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            bit_q      <= '0;
            sar_q      <= adcct_pkg::RES_ZERO;
            dac_code_q <= adcct_pkg::RES_ZERO;
        end else begin
            unique case (state_q)
                ADCCT_SAMPLE: begin
                    if (cnt_done) begin
                        bit_q      <= adcct_pkg::BIT_TOP;
                        sar_q      <= adcct_pkg::RES_ZERO;
                        dac_code_q <= adcct_pkg::RES_MSB;
                    end
                end
                ADCCT_COMPARE: begin
                    if (cnt_done) begin
                        sar_q <= sar_keep;
                        if (bit_q != '0) begin
                            bit_q      <= bit_q - adcct_pkg::BIT_W'(1);
                            dac_code_q <= sar_keep | bit_mask(bit_q - adcct_pkg::BIT_W'(1));
                        end else begin
                            dac_code_q <= sar_keep;
                        end
                    end
                end
                ADCCT_IDLE: begin
                    // park the trial level at ground between conversions
                    dac_code_q <= adcct_pkg::RES_ZERO;
                end
                ADCCT_XFER: begin
                    bit_q <= bit_q;
                end
            endcase
        end
    end

    // result register loads at the end of the transfer phase; an input
    // out of range overrides whatever the comparator decided
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            result_q        <= adcct_pkg::RES_ZERO;
            range_clamped_q <= 1'b0;
        end else if (conv_end) begin
            if (below_q) begin
                result_q <= adcct_pkg::RES_ZERO;
            end else if (above_q) begin
                result_q <= adcct_pkg::RES_FULL;
            end else begin
                result_q <= sar_q;
            end
            range_clamped_q <= below_q || above_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            result_valid_q <= 1'b0;
        end else begin
            result_valid_q <= conv_end;
        end
    end

    // status view of the sequencer
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            busy_q  <= 1'b0;
            phase_q <= adcct_pkg::PH_IDLE;
        end else begin
            busy_q <= (state_d != ADCCT_IDLE);
            unique case (state_d)
                ADCCT_IDLE:    phase_q <= adcct_pkg::PH_IDLE;
                ADCCT_SAMPLE:  phase_q <= adcct_pkg::PH_SAMPLE;
                ADCCT_COMPARE: phase_q <= adcct_pkg::PH_COMPARE;
                ADCCT_XFER:    phase_q <= adcct_pkg::PH_XFER;
            endcase
        end
    end

    // analog power follows the control bit; a running conversion is dropped
    // rather than finished, since its comparator would be dead anyway
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            analog_en_q <= 1'b0;
        end else begin
            analog_en_q <= !pwr_off;
        end
    end

endmodule

// file: rtl/adcct_pkg.sv
// adcct_pkg: constants shared by the converter timing controller and its timing table.
// assumes a single 20 MHz reference clock that also serves as the cpu clock.
package adcct_pkg;

    // control word layout
    localparam int CTRL_W      = 16;
    localparam int CTC_MSB     = 15;
    localparam int CTC_LSB     = 14;
    localparam int STC_MSB     = 13;
    localparam int STC_LSB     = 12;
    localparam int PWR_OFF_BIT = 6;

    // converter geometry
    localparam int RES_W     = 10;
    localparam int SAR_STEPS = 10;
    localparam int BIT_W     = 4;
    localparam int CNT_W     = 11;
    localparam int IDX_W     = 4;

    // one half_clock_unit is half a cpu clock period
    localparam int TCL_PER_CLK = 2;

    // conversion_time_code encodings and their table rows
    localparam logic [1:0] CTC_FAST   = 2'h0;
    localparam logic [1:0] CTC_UNDOC  = 2'h1;
    localparam logic [1:0] CTC_SLOW   = 2'h2;
    localparam logic [1:0] CTC_MEDIUM = 2'h3;
    localparam logic [1:0] ROW_FAST   = 2'h0;
    localparam logic [1:0] ROW_MEDIUM = 2'h1;
    localparam logic [1:0] ROW_SLOW   = 2'h2;

    // phase lengths in half_clock_unit, indexed by row*4 + sample_time_code
    localparam int SMP_TCL [12] = '{120, 140, 200, 400,
                                    240, 280, 400, 800,
                                    480, 560, 800, 1600};
    localparam int CMP_TCL [12] = '{240, 280, 280, 280,
                                    480, 560, 560, 560,
                                    960, 1120, 1120, 1120};
    localparam int EXT_TCL [12] = '{28, 16, 52, 44,
                                    52, 28, 100, 52,
                                    100, 52, 196, 64};

    // result constants
    localparam logic [RES_W-1:0] RES_ZERO = 10'h000;
    localparam logic [RES_W-1:0] RES_FULL = 10'h3ff;
    localparam logic [RES_W-1:0] RES_MSB  = 10'h200;
    localparam logic [BIT_W-1:0] BIT_TOP  = 4'h9;

    // phase codes shown on the status port
    localparam logic [1:0] PH_IDLE    = 2'h0;
    localparam logic [1:0] PH_SAMPLE  = 2'h1;
    localparam logic [1:0] PH_COMPARE = 2'h2;
    localparam logic [1:0] PH_XFER    = 2'h3;

endpackage

// file: rtl/adcct_timing_rom.sv
// adcct_timing_rom: registered lookup of phase lengths in reference clock cycles.
// assumes the codes come from the same clock domain; answers one cycle later.
`timescale 1ns/1ps
module adcct_timing_rom (
    // clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          rstn,
    // timing selection
    input  wire logic [1:0]                    ctc,
    input  wire logic [1:0]                    stc,
    // phase lengths in cycles
    output logic      [adcct_pkg::CNT_W-1:0]   smp_cyc_q,
    output logic      [adcct_pkg::CNT_W-1:0]   step_cyc_q,
    output logic      [adcct_pkg::CNT_W-1:0]   ext_cyc_q
);

    logic [1:0]                  row;
    logic [adcct_pkg::IDX_W-1:0] idx;

    // undocumented code falls back to the fastest set
    always_comb begin
        unique case (ctc)
            adcct_pkg::CTC_FAST:   row = adcct_pkg::ROW_FAST;
            adcct_pkg::CTC_UNDOC:  row = adcct_pkg::ROW_FAST;
            adcct_pkg::CTC_MEDIUM: row = adcct_pkg::ROW_MEDIUM;
            adcct_pkg::CTC_SLOW:   row = adcct_pkg::ROW_SLOW;
        endcase
    end

    assign idx = {row, stc};

    // comparison phase split evenly over the ten decision steps
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            smp_cyc_q  <= '0;
            step_cyc_q <= '0;
            ext_cyc_q  <= '0;
        end else begin
            smp_cyc_q  <= adcct_pkg::CNT_W'(adcct_pkg::SMP_TCL[idx]
                          / adcct_pkg::TCL_PER_CLK);
            step_cyc_q <= adcct_pkg::CNT_W'(adcct_pkg::CMP_TCL[idx]
                          / (adcct_pkg::TCL_PER_CLK * adcct_pkg::SAR_STEPS));
            ext_cyc_q  <= adcct_pkg::CNT_W'(adcct_pkg::EXT_TCL[idx]
                          / adcct_pkg::TCL_PER_CLK);
        end
    end

endmodule

// file: sim/adcct_ctrl_asserts.sv
// adcct_ctrl_asserts: concurrent checks on the converter timing controller ports.
// assumes it is bound into every adcct_ctrl instance; single clock domain.
`timescale 1ns/1ps
module adcct_ctrl_asserts (
    // clock and reset
    input wire logic                         ref_clk,
    input wire logic                         rstn,
    // watched outputs
    input wire logic                         analog_en_q,
    input wire logic                         sample_sw_q,
    input wire logic [adcct_pkg::RES_W-1:0]  dac_code_q,
    input wire logic                         busy_q,
    input wire logic [1:0]                   phase_q,
    input wire logic [adcct_pkg::RES_W-1:0]  result_q,
    input wire logic                         result_valid_q,
    input wire logic                         range_clamped_q
);
    logic [1:0]  ph_q;
    logic [11:0] cnt_q;

    // length of the phase just left, readable in the cycle the phase changes
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ph_q  <= 2'h0;
            cnt_q <= 12'h000;
        end else begin
            ph_q  <= phase_q;
            cnt_q <= (phase_q != ph_q) ? 12'h001 : cnt_q + 12'h001;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_sample_len: assert property (
        (phase_q == adcct_pkg::PH_COMPARE && ph_q == adcct_pkg::PH_SAMPLE) |->
        cnt_q inside {12'h3c, 12'h46, 12'h64, 12'h78, 12'h8c, 12'hc8, 12'hf0, 12'h118,
                      12'h190, 12'h320}) else $error("sample phase length off");
    a_msb_first: assert property (
        (phase_q == adcct_pkg::PH_COMPARE && ph_q == adcct_pkg::PH_SAMPLE) |->
        dac_code_q == adcct_pkg::RES_MSB) else $error("first trial is not the top bit");
    a_compare_len: assert property (
        (phase_q == adcct_pkg::PH_XFER && ph_q == adcct_pkg::PH_COMPARE) |->
        cnt_q inside {12'h78, 12'h8c, 12'hf0, 12'h118, 12'h1e0, 12'h230})
        else $error("compare phase length off");
    a_xfer_done: assert property (
        (phase_q == adcct_pkg::PH_IDLE && ph_q == adcct_pkg::PH_XFER && analog_en_q) |->
        result_valid_q && cnt_q inside {12'h8, 12'he, 12'h16, 12'h1a, 12'h20, 12'h32, 12'h62})
        else $error("transfer phase wrong");
    a_valid_pulse: assert property (
        result_valid_q |-> (phase_q == adcct_pkg::PH_IDLE && !busy_q) ##1 !result_valid_q)
        else $error("result strobe not a lone pulse at idle");
    a_sample_sw: assert property (
        sample_sw_q == (phase_q == adcct_pkg::PH_SAMPLE)) else $error("switch and phase differ");
    a_busy_phase: assert property (
        busy_q == (phase_q != adcct_pkg::PH_IDLE)) else $error("busy and phase differ");
    a_power_idle: assert property (
        !analog_en_q |-> !busy_q && !sample_sw_q) else $error("converting while powered off");
    a_clamp_value: assert property (
        result_valid_q && range_clamped_q |->
        result_q == adcct_pkg::RES_ZERO || result_q == adcct_pkg::RES_FULL)
        else $error("clamped result not a rail value");
    a_result_hold: assert property (
        !result_valid_q |-> $stable(result_q) && $stable(range_clamped_q))
        else $error("result moved without strobe");
endmodule

bind adcct_ctrl adcct_ctrl_asserts u_asserts (
    .ref_clk(ref_clk), .rstn(rstn), .analog_en_q(analog_en_q), .sample_sw_q(sample_sw_q),
    .dac_code_q(dac_code_q), .busy_q(busy_q), .phase_q(phase_q), .result_q(result_q),
    .result_valid_q(result_valid_q), .range_clamped_q(range_clamped_q)
);

// file: sim/adcct_analog_src.sv
// adcct_analog_src: analog source with sample-and-hold and comparator, in codes.
// assumes vin below 0 or above 1023 means outside ground or reference.
`timescale 1ns/1ps
module adcct_analog_src (
    // clock and converter controls
    input  wire logic                         ref_clk,
    input  wire logic                         analog_en_q,
    input  wire logic                         sample_sw_q,
    input  wire logic [adcct_pkg::RES_W-1:0]  dac_code_q,
    // source level
    input  var  int                           vin,
    // comparator and range detectors
    output logic                              cmp_above,
    output logic                              in_below_gnd,
    output logic                              in_above_ref
);
    int   held = 0;
    logic tgl  = 1'b0;

    always @(posedge ref_clk) begin
        tgl <= ~tgl;
        if (sample_sw_q) begin
            held <= vin;
        end
    end

    // unpowered analog gives no valid answer, so the lines wander
    assign cmp_above    = analog_en_q ? (held >= int'(dac_code_q)) : tgl;
    assign in_below_gnd = analog_en_q ? (vin < 0) : tgl;
    assign in_above_ref = analog_en_q ? (vin > 32'sh3ff) : ~tgl;
endmodule

// file: sim/tb_adc_conversion_timing.sv
// tb_adc_conversion_timing: self-checking bench for the converter timing controller.
// assumes adcct_ctrl, adcct_analog_src and the bound checker; one 20 MHz clock.
`timescale 1ns/1ps
module tb_adc_conversion_timing;
    logic                         ref_clk;
    logic                         rstn;
    logic [adcct_pkg::CTRL_W-1:0] ctrl_word;
    logic                         conv_start;
    logic                         cmp_above;
    logic                         in_below_gnd;
    logic                         in_above_ref;
    logic                         analog_en_q;
    logic                         sample_sw_q;
    logic [adcct_pkg::RES_W-1:0]  dac_code_q;
    logic                         busy_q;
    logic [1:0]                   phase_q;
    logic [adcct_pkg::RES_W-1:0]  result_q;
    logic                         result_valid_q;
    logic                         range_clamped_q;
    int                           vin;
    int                           num_errors;
    int                           n_checks;
    // totals in half_clock_unit by {conversion_time_code, sample_time_code}
    int tot_tcl [16] = '{12'h184, 12'h1b4, 12'h214, 12'h2d4,
                         12'h184, 12'h1b4, 12'h214, 12'h2d4,
                         12'h604, 12'h6c4, 12'h844, 12'hae0,
                         12'h304, 12'h364, 12'h424, 12'h584};

    adcct_ctrl uut (.ref_clk, .rstn, .ctrl_word, .conv_start, .cmp_above, .in_below_gnd,
        .in_above_ref, .analog_en_q, .sample_sw_q, .dac_code_q, .busy_q, .phase_q,
        .result_q, .result_valid_q, .range_clamped_q);
    adcct_analog_src src (.ref_clk, .analog_en_q, .sample_sw_q, .dac_code_q, .vin,
        .cmp_above, .in_below_gnd, .in_above_ref);

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one conversion; the source moves to late once comparison has begun
    task automatic conv(input logic [3:0] code, input int v, input int late);
        int                          n;
        logic [adcct_pkg::RES_W-1:0] exp_res;
        n = 0;
        exp_res = (v < 0) ? 10'h000 : (v > 32'sh3ff) ? 10'h3ff : v[9:0];
        @(posedge ref_clk);
        ctrl_word <= {code, 12'($urandom) & 12'hfbf};
        vin <= v;
        repeat (2) @(posedge ref_clk);
        conv_start <= 1'b1;
        @(posedge ref_clk);
        conv_start <= 1'b0;
        while (n < 1500 && result_valid_q !== 1'b1) begin
            @(negedge ref_clk);
            n++;
            if (phase_q === adcct_pkg::PH_COMPARE) begin
                vin = late;
            end
        end
        check(n === tot_tcl[code] / adcct_pkg::TCL_PER_CLK + 1, "conversion length");
        check(result_q === exp_res, "result value");
        check(range_clamped_q === (v < 0 || v > 32'sh3ff), "clamp flag");
    endtask

    initial begin
        int                          v;
        int                          bad;
        logic [adcct_pkg::RES_W-1:0] last;
        rstn = 1'b0;
        ctrl_word = 16'h0000;
        conv_start = 1'b0;
        vin = 0;
        num_errors = 0;
        n_checks = 0;
        bad = 0;
        v = $urandom(32'h1aa0e146);
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (2) @(negedge ref_clk);
        check(analog_en_q === 1'b1 && busy_q === 1'b0, "idle after reset");
        for (int i = 0; i < 16; i++) begin
            case (i % 4)
                0: v = -32'sh3;
                1: v = 32'sh406;
                2: v = int'($urandom_range(32'h3ff));
                default: v = (i < 8) ? 32'sh0 : 32'sh3ff;
            endcase
            conv(i[3:0], v, int'($urandom_range(32'h44c)) - 32'sh28);
        end
        // power off in mid conversion, then starts while off are ignored
        last = result_q;
        @(posedge ref_clk);
        conv_start <= 1'b1;
        @(posedge ref_clk);
        conv_start <= 1'b0;
        repeat (30) @(posedge ref_clk);
        ctrl_word[adcct_pkg::PWR_OFF_BIT] <= 1'b1;
        repeat (2) @(negedge ref_clk);
        check(busy_q === 1'b0 && analog_en_q === 1'b0, "power off abort");
        @(posedge ref_clk);
        conv_start <= 1'b1;
        repeat (1500) @(negedge ref_clk) bad += (busy_q !== 1'b0 || result_valid_q !== 1'b0);
        check(bad === 0 && result_q === last, "activity while off");
        @(posedge ref_clk);
        conv_start <= 1'b0;
        ctrl_word[adcct_pkg::PWR_OFF_BIT] <= 1'b0;
        conv(4'h5, 32'sh155, 32'sh2aa);
        wrap_up();
    end

    initial begin
        repeat (40000) @(posedge ref_clk);
        num_errors++;
        wrap_up();
    end
endmodule
